// ### include/plw_pkg.sv
package plw_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CONFIG     = 16'hFF98;
    localparam logic [15:0] ADDR_SERVICE    = 16'hFF99;
    localparam logic [15:0] ADDR_CAUSE      = 16'hFFA0;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFFA1;
    localparam logic [15:0] ADDR_IRQ_MASK   = 16'hFFA2;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int          CFG_STOP_BIT     = 4;
    localparam int          CFG_CLK_BIT      = 3;
    localparam logic [2:0]  CFG_TOP_FIXED    = 3'h3;
    localparam logic [7:0]  CONFIG_RESET     = 8'h67;
    localparam logic [2:0]  INTERVAL_LONGEST = 3'h7;
    localparam logic [7:0]  SERVICE_KEY      = 8'hAC;
    localparam logic [7:0]  SERVICE_READ     = 8'h9A;
    localparam int          CAUSE_WDT_BIT    = 4;
    localparam int          EVT_EXPIRE_BIT   = 0;
    localparam int          EVT_BADKEY_BIT   = 1;
    localparam int          EVT_REWRITE_BIT  = 2;
    localparam int          EVT_WIDTH        = 3;

    // ------------------------------------------------------------
    // Interval counts, as powers of two of the selected clock
    // ------------------------------------------------------------
    localparam logic [4:0]  OSC_BASE_EXP     = 5'h0B;
    localparam logic [4:0]  HS_BASE_EXP      = 5'h0D;
    localparam int          COUNT_WIDTH      = 20;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } plw_bus_s;

    typedef struct packed {
        logic halt;
        logic stop;
        logic hs_stopped;
        logic osc_stabilizing;
        logic cpu_on_hs;
        logic osc_sw_stopped;
    } plw_standby_s;

    typedef enum logic {
        PLW_SRC_OSC,
        PLW_SRC_HS
    } plw_src_e;

endpackage

// ### src/plw_watchdog.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
// How it works
// R1: Unserviced interval expiry raises internal reset
// R2: Watchdog reset sets cause flag bit 4
// R3: Oscillator intervals 2^11 to 2^18 cycles
// R4: High-speed intervals 2^13 to 2^20 cycles
// R5: Locked option: oscillator only, never stops
// R6: Stoppable option: software picks clock or stop
// R7: Counts from release at longest oscillator interval
// R8: Interval and clock accepted only once
// R9: Stoppable mode pauses while clock gated
// R10: High-speed source gated when stopped or standby
// R11: Oscillator source gated in standby or stopped
// R12: Locked oscillator runs except during reset
// R13: Writing ACH clears counter and restarts
// R14: Other service values reset, deferred if gated
// R15: Second config write raises internal reset
// R16: Select 00 oscillator, 01 high-speed, 1x stop
// R17: Binary counter, setting picks expiry power
module plw_watchdog (
    input  wire logic                  REF_CLK,
    input  wire logic                  RESET,
    input  wire plw_pkg::plw_bus_s     BUS_REQ,
    input  wire plw_pkg::plw_standby_s STANDBY,
    input  wire logic                  OSC_TICK,
    input  wire logic                  HS_TICK,
    input  wire logic                  OSC_LOCKED_STRAP,
    output logic [7:0]                 RD_DATA,
    output logic                       INT_RESET,
    output logic                       IRQ,
    output logic                       OSC_RUN
);
    import plw_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [COUNT_WIDTH-1:0] limit_of(input plw_src_e src,
                                                        input logic [2:0] sel);
        logic [4:0]  e;
        logic [20:0] full;
        e    = (src == PLW_SRC_HS) ? HS_BASE_EXP + {2'h0, sel}
                                   : OSC_BASE_EXP + {2'h0, sel};
        full = (21'h00_0001 << e) - 21'h00_0001;
        return full[COUNT_WIDTH-1:0];
    endfunction

    function automatic logic hit(input plw_bus_s b, input logic [15:0] a);
        return b.addr == a;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic                   locked_reg;
    logic                   strap_taken_reg;
    plw_src_e               src_reg;
    logic                   stopped_reg;
    logic [2:0]             sel_reg;
    logic                   written_reg;
    logic [COUNT_WIDTH-1:0] count_reg;
    logic                   pend_reg;
    logic                   int_reset_reg;
    logic                   cause_reg;
    logic [EVT_WIDTH-1:0]   stat_reg;
    logic [EVT_WIDTH-1:0]   mask_reg;
    logic [7:0]             rd_data_reg;
    logic                   irq_reg;

    logic                   cfg_wr;
    logic                   svc_wr;
    logic                   svc_ok;
    logic                   gate_open;
    logic                   tick;
    logic                   expire;
    logic                   fault;
    logic                   fire;
    logic [EVT_WIDTH-1:0]   events;
    logic [EVT_WIDTH-1:0]   stat_next;
    logic                   cause_next;
    logic [7:0]             rd_next;

    assign cfg_wr = BUS_REQ.wr && hit(BUS_REQ, ADDR_CONFIG);
    assign svc_wr = BUS_REQ.wr && hit(BUS_REQ, ADDR_SERVICE);
    assign svc_ok = svc_wr && (BUS_REQ.wdata == SERVICE_KEY);

    // ------------------------------------------------------------
    // Clock gating of the selected source
    // ------------------------------------------------------------
    always_comb begin
        if (locked_reg) begin
            gate_open = 1'b1; // R5 R12
        end else if (src_reg == PLW_SRC_HS) begin
            gate_open = !STANDBY.hs_stopped && !STANDBY.halt && !STANDBY.stop
                        && !STANDBY.osc_stabilizing; // R10
        end else begin
            gate_open = !STANDBY.halt && !STANDBY.stop
                        && !(STANDBY.cpu_on_hs && STANDBY.osc_sw_stopped); // R11
        end
    end

    assign tick   = gate_open && !stopped_reg
                    && ((src_reg == PLW_SRC_HS) ? HS_TICK : OSC_TICK); // R9
    assign expire = tick && (count_reg == limit_of(src_reg, sel_reg)); // R1 R17
    assign fault  = (svc_wr && !svc_ok) || (cfg_wr && written_reg); // R14 R15
    assign fire   = !int_reset_reg
                    && (expire || (gate_open && (fault || pend_reg))); // R14

    // ------------------------------------------------------------
    // Boot option capture
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            locked_reg      <= 1'b1;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            locked_reg      <= OSC_LOCKED_STRAP;
            strap_taken_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration, write once
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            src_reg     <= PLW_SRC_OSC; // R6 R7
            stopped_reg <= 1'b0;
            sel_reg     <= INTERVAL_LONGEST; // R7
            written_reg <= 1'b0;
        end else if (int_reset_reg) begin
            src_reg     <= PLW_SRC_OSC;
            stopped_reg <= 1'b0;
            sel_reg     <= INTERVAL_LONGEST;
            written_reg <= 1'b0;
        end else if (cfg_wr && !written_reg) begin
            written_reg <= 1'b1; // R8
            sel_reg     <= BUS_REQ.wdata[2:0]; // R3 R4
            if (!locked_reg) begin
                stopped_reg <= BUS_REQ.wdata[CFG_STOP_BIT]; // R16
                src_reg     <= BUS_REQ.wdata[CFG_CLK_BIT] ? PLW_SRC_HS
                                                          : PLW_SRC_OSC; // R16 R6
            end
        end
    end

    // ------------------------------------------------------------
    // Interval counter
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            count_reg <= '0;
        end else if (int_reset_reg || svc_ok || expire) begin
            count_reg <= '0; // R13
        end else if (tick) begin
            count_reg <= count_reg + 1'b1; // R17
        end
    end

    // ------------------------------------------------------------
    // Internal reset and deferred faults
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            pend_reg      <= 1'b0;
            int_reset_reg <= 1'b0;
        end else begin
            int_reset_reg <= fire; // R1
            if (fire || int_reset_reg) begin
                pend_reg <= 1'b0;
            end else if (fault && !gate_open) begin
                pend_reg <= 1'b1; // R14
            end
        end
    end

    // ------------------------------------------------------------
    // Reset cause flag, write one to clear, set wins
    // ------------------------------------------------------------
    always_comb begin
        cause_next = cause_reg;
        if (BUS_REQ.wr && hit(BUS_REQ, ADDR_CAUSE) && BUS_REQ.wdata[CAUSE_WDT_BIT]) begin
            cause_next = 1'b0;
        end
        if (fire) begin
            cause_next = 1'b1; // R2
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            cause_reg <= 1'b0;
        end else begin
            cause_reg <= cause_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        events                  = '0;
        events[EVT_EXPIRE_BIT]  = expire && !int_reset_reg;
        events[EVT_BADKEY_BIT]  = svc_wr && !svc_ok && !int_reset_reg;
        events[EVT_REWRITE_BIT] = cfg_wr && written_reg && !int_reset_reg;
        stat_next               = stat_reg;
        if (BUS_REQ.wr && hit(BUS_REQ, ADDR_IRQ_STATUS)) begin
            stat_next = stat_reg & ~BUS_REQ.wdata[EVT_WIDTH-1:0];
        end
        stat_next = stat_next | events;
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            stat_reg <= '0;
            mask_reg <= '0;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg  <= |(stat_next & mask_reg);
            if (BUS_REQ.wr && hit(BUS_REQ, ADDR_IRQ_MASK)) begin
                mask_reg <= BUS_REQ.wdata[EVT_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        rd_next = 8'h00;
        if (BUS_REQ.rd) begin
            unique case (BUS_REQ.addr)
                ADDR_CONFIG: begin
                    rd_next = {CFG_TOP_FIXED, stopped_reg, src_reg == PLW_SRC_HS, sel_reg};
                end
                ADDR_SERVICE: begin
                    rd_next = SERVICE_READ;
                end
                ADDR_CAUSE: begin
                    rd_next[CAUSE_WDT_BIT] = cause_reg;
                end
                ADDR_IRQ_STATUS: begin
                    rd_next[EVT_WIDTH-1:0] = stat_reg;
                end
                ADDR_IRQ_MASK: begin
                    rd_next[EVT_WIDTH-1:0] = mask_reg;
                end
                default: begin
                    rd_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_next;
        end
    end

    assign RD_DATA   = rd_data_reg;
    assign INT_RESET = int_reset_reg;
    assign IRQ       = irq_reg;
    assign OSC_RUN   = strap_taken_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_deferred_fault;
        fault && !gate_open && !int_reset_reg && !expire;
    endsequence

    sequence s_gate_reopens;
        gate_open [*1];
    endsequence

    AST_EXPIRE_RESETS: assert property (@(posedge REF_CLK) disable iff (RESET) // R1
        expire && !int_reset_reg |=> INT_RESET ##1 !INT_RESET)
        else $error("expiry did not give one reset pulse");

    AST_CAUSE_FLAG: assert property (@(posedge REF_CLK) disable iff (RESET) // R2
        INT_RESET |-> cause_reg)
        else $error("reset cause flag not set");

    AST_LIMIT_RANGE: assert property (@(posedge REF_CLK) disable iff (RESET) // R3
        expire && src_reg == PLW_SRC_OSC
        |-> {1'b0, count_reg} == ((21'h00_0001 << OSC_BASE_EXP) << sel_reg) - 21'h00_0001)
        else $error("oscillator interval wrong");

    AST_HS_LIMIT: assert property (@(posedge REF_CLK) disable iff (RESET) // R4
        expire && src_reg == PLW_SRC_HS
        |-> {1'b0, count_reg} == ((21'h00_0001 << HS_BASE_EXP) << sel_reg) - 21'h00_0001)
        else $error("high-speed interval wrong");

    AST_LOCKED_SOURCE: assert property (@(posedge REF_CLK) disable iff (RESET) // R5
        locked_reg |-> src_reg == PLW_SRC_OSC && !stopped_reg && gate_open)
        else $error("locked watchdog left the oscillator");

    AST_RELEASE_LONGEST: assert property (@(posedge REF_CLK) disable iff (RESET) // R7
        !written_reg |-> sel_reg == 3'h7 && src_reg == PLW_SRC_OSC)
        else $error("default interval not the longest");

    AST_WRITE_ONCE: assert property (@(posedge REF_CLK) disable iff (RESET) // R8
        written_reg && !int_reset_reg |=> $stable(sel_reg) && $stable(src_reg))
        else $error("configuration changed after first write");

    AST_GATED_HOLD: assert property (@(posedge REF_CLK) disable iff (RESET) // R9
        !gate_open && !svc_ok && !int_reset_reg |=> $stable(count_reg))
        else $error("counter moved while gated");

    AST_SERVICE_CLEARS: assert property (@(posedge REF_CLK) disable iff (RESET) // R13
        svc_ok |=> count_reg == 20'h0_0000)
        else $error("service write did not clear counter");

    AST_DEFERRED: assert property (@(posedge REF_CLK) disable iff (RESET) // R14
        s_deferred_fault ##1 s_gate_reopens |=> INT_RESET)
        else $error("deferred fault not raised on resume");

    AST_REWRITE_RESET: assert property (@(posedge REF_CLK) disable iff (RESET) // R15
        cfg_wr && written_reg && gate_open && !int_reset_reg |=> INT_RESET)
        else $error("second config write gave no reset");

    AST_BADKEY_RESET: assert property (@(posedge REF_CLK) disable iff (RESET) // R14
        svc_wr && !svc_ok && gate_open && !int_reset_reg |=> INT_RESET)
        else $error("wrong service value gave no reset");

    AST_PEND_RESUMES: assert property (@(posedge REF_CLK) disable iff (RESET) // R14
        pend_reg && gate_open && !int_reset_reg |=> INT_RESET)
        else $error("pending fault not raised when clock resumed");

    AST_STOP_FREEZE: assert property (@(posedge REF_CLK) disable iff (RESET) // R16
        stopped_reg && !svc_ok && !int_reset_reg |=> $stable(count_reg))
        else $error("counter moved while stopped");

    AST_EXPIRE_STATUS: assert property (@(posedge REF_CLK) disable iff (RESET) // R1
        expire && !int_reset_reg |=> stat_reg[EVT_EXPIRE_BIT])
        else $error("expiry status bit not set");

    AST_IRQ_LEVEL: assert property (@(posedge REF_CLK) disable iff (RESET)
        ##1 IRQ == |($past(stat_next) & $past(mask_reg)))
        else $error("interrupt level wrong");

endmodule

// ### verif/tb_plw_watchdog.sv
`timescale 1ns/10ps
module tb_plw_watchdog;
    import plw_pkg::*;
    logic         ref_clk;
    logic         reset;
    logic         strap;
    logic         osc_tick;
    logic         hs_tick;
    logic         int_reset;
    logic         irq;
    logic         osc_run;
    logic [7:0]   rd_data;
    logic [7:0]   d;
    plw_bus_s     bus;
    plw_standby_s stby;
    int           n_errors;
    int           checks_done;
    int           n;

    plw_watchdog dut (
        .REF_CLK          (ref_clk),
        .RESET            (reset),
        .BUS_REQ          (bus),
        .STANDBY          (stby),
        .OSC_TICK         (osc_tick),
        .HS_TICK          (hs_tick),
        .OSC_LOCKED_STRAP (strap),
        .RD_DATA          (rd_data),
        .INT_RESET        (int_reset),
        .IRQ              (irq),
        .OSC_RUN          (osc_run)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task finish_test;
        $display("Counts: %0d checks, %0d errors", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chkr(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask

    task rd(input logic [15:0] a);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        d = rd_data;
    endtask

    // Cycles until the internal reset pulse; a missing pulse ends the run
    task wait_rst(input int max);
        n = 0;
        #1;
        while (int_reset !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > max) begin
                n_errors++;
                $display("Error INT_RESET expected pulse seen none");
                finish_test;
            end
        end
    endtask

    task quiet(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge ref_clk);
            #1;
            if (int_reset === 1'b1) n++;
        end
        chkr("reset pulses", 0, 0, n);
    endtask

    task do_reset(input logic s);
        strap <= s;
        reset <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk8("osc run in reset", 8'h00, {7'h00, osc_run});
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task run_cfg(input logic [7:0] cfg, input int exp);
        wr(ADDR_CONFIG, cfg);
        wr(ADDR_SERVICE, SERVICE_KEY);
        wait_rst(exp + 20);
        chkr("expiry cycles", exp - 2, exp + 3, n);
    endtask

    task clear_events(input logic [7:0] exp);
        rd(ADDR_IRQ_STATUS);
        chk8("irq status", exp, d);
        wr(ADDR_IRQ_STATUS, 8'h07);
        wr(ADDR_CAUSE, 8'h10);
        rd(ADDR_CAUSE);
        chk8("cause cleared", 8'h00, d);
        chk8("irq cleared", 8'h00, {7'h00, irq});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        strap = 1'b1;
        osc_tick = 1'b1;
        hs_tick = 1'b1;
        bus = '0;
        stby = '0;
        n_errors = 0;
        checks_done = 0;
        do_reset(1'b1);
        rd(ADDR_CONFIG);
        chk8("config reset", CONFIG_RESET, d);
        rd(ADDR_SERVICE);
        chk8("service read", SERVICE_READ, d);
        rd(ADDR_CAUSE);
        chk8("cause reset", 8'h00, d);
        rd(16'hFFA3);
        chk8("unmapped read", 8'h00, d);
        chk8("osc run", 8'h01, {7'h00, osc_run});
        quiet(3000);
        wr(ADDR_IRQ_MASK, 8'h07);
        $display("Test reset values done");

        for (int i = 0; i < 3; i++) begin
            run_cfg(8'h60 | 8'(i * 9), 2048 << i);
            #1;
            chk8("irq raised", 8'h01, {7'h00, irq});
            rd(ADDR_CAUSE);
            chk8("cause flag", 8'h01 << CAUSE_WDT_BIT, d);
            clear_events(8'h01);
        end
        $display("Test locked intervals done");

        wr(ADDR_CONFIG, 8'h60);
        wr(ADDR_CONFIG, 8'h61);
        wait_rst(4);
        chkr("rewrite reset", 0, 4, n);
        clear_events(8'h04);
        wr(ADDR_SERVICE, 8'h00);
        wait_rst(4);
        chkr("bad key reset", 0, 4, n);
        clear_events(8'h02);
        wr(ADDR_CONFIG, 8'h60);
        wr(ADDR_SERVICE, SERVICE_KEY);
        quiet(1500);
        wr(ADDR_SERVICE, SERVICE_KEY);
        quiet(1500);
        wait_rst(700);
        chkr("serviced expiry", 540, 560, n);
        clear_events(8'h01);
        $display("Test refusals and service done");

        do_reset(1'b0);
        rd(ADDR_CONFIG);
        chk8("config reset", CONFIG_RESET, d);
        wr(ADDR_CONFIG, 8'h68);
        wr(ADDR_SERVICE, SERVICE_KEY);
        quiet(1000);
        stby.hs_stopped <= 1'b1;
        quiet(3000);
        stby.hs_stopped <= 1'b0;
        wait_rst(8000);
        chkr("hs gated expiry", 7187, 7198, n);
        clear_events(8'h01);
        wr(ADDR_CONFIG, 8'h60);
        wr(ADDR_SERVICE, SERVICE_KEY);
        stby.stop <= 1'b1;
        quiet(3000);
        stby.stop <= 1'b0;
        wait_rst(2100);
        chkr("osc gated expiry", 2040, 2055, n);
        clear_events(8'h01);
        stby.halt <= 1'b1;
        wr(ADDR_SERVICE, 8'h00);
        quiet(50);
        stby.halt <= 1'b0;
        wait_rst(4);
        chkr("deferred bad key", 0, 4, n);
        clear_events(8'h02);
        stby.halt <= 1'b1;
        wr(ADDR_SERVICE, 8'h00);
        stby.halt <= 1'b0;
        wait_rst(4);
        chkr("resumed bad key", 0, 4, n);
        clear_events(8'h02);
        wr(ADDR_IRQ_MASK, 8'h05);
        rd(ADDR_IRQ_MASK);
        chk8("irq mask", 8'h05, d);
        wr(ADDR_CONFIG, 8'h70);
        quiet(5000);
        wr(ADDR_SERVICE, 8'h00);
        wait_rst(4);
        chkr("stopped bad key", 0, 4, n);
        chk8("irq masked", 8'h00, {7'h00, irq});
        clear_events(8'h02);
        $display("Test stoppable mode done");
        finish_test;
    end
endmodule
